/* src/sepi_params.svh */
// timing, opcode and field constants for the serial eeprom pin front end
`ifndef SEPI_PARAMS_SVH
`define SEPI_PARAMS_SVH
`define SEPI_OP_OP_WRITE_ENABLE_CODE   8'h06
`define SEPI_OP_OP_WRITE_DISABLE_CODE   8'h04
`define SEPI_OP_OP_STATUS_READ_CODE   8'h05
`define SEPI_OP_OP_STATUS_WRITE_CODE   8'h01
`define SEPI_OP_READ_CODE   8'h03
`define SEPI_OP_WRITE_CODE  8'h02
`define SEPI_SR_BUSY_POS    0
`define SEPI_SR_WEL_POS     1
`define SEPI_SR_BPLO_POS    2
`define SEPI_SR_BPHI_POS    3
`define SEPI_SR_LOCK_POS    7
`define SEPI_SR_RESET       8'h00
`define SEPI_CLK_MHZ        200
`define SEPI_WRITE_MS       5
`define SEPI_WRITE_CYC      (`SEPI_WRITE_MS * 1000 * `SEPI_CLK_MHZ)
`define SEPI_BIT_LAST       3'h7
`endif

/* src/sepi_pkg.sv */
// types shared by the serial eeprom pin front end
package sepi_pkg;
    // transfer phase of one select frame
    typedef enum logic [2:0] {
        SEPI_IDLE   = 3'b000,
        SEPI_OPCODE = 3'b001,
        SEPI_SRTX   = 3'b010,
        SEPI_SRRX   = 3'b011,
        SEPI_PASS   = 3'b100,
        SEPI_WAIT   = 3'b101
    } sepi_phase_e;
endpackage

/* src/sepi_buf_if.sv */
// handshake carrier between the front end and its output buffer
`timescale 1ns/1ps
interface sepi_buf_if #(parameter int W = 8);
    logic         valid;  // producer has a word
    logic         ready;  // consumer takes it
    logic [W-1:0] data;   // the word
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sepi_buf_if

/* src/sepi_skid.sv */
// two-entry buffer that keeps received bytes while the user side stalls
`timescale 1ns/1ps
module sepi_skid #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // fill and drain sides
    sepi_buf_if.snk   in_if,
    sepi_buf_if.src   out_if
);
    logic [W-1:0] mem_ff [2];    // storage words
    logic [W-1:0] nxt_mem [2];
    logic         wp_ff, rp_ff;  // write and read slots
    logic         nxt_wp, nxt_rp;
    logic [1:0]   cnt_ff, nxt_cnt; // words held
    logic         push, pop;

    // next state: push into the write slot, pop from the read slot
    always_comb begin
        push       = in_if.valid && (cnt_ff != 2'h2);
        pop        = (cnt_ff != 2'h0) && out_if.ready;
        nxt_mem    = mem_ff;
        nxt_wp     = wp_ff;
        nxt_rp     = rp_ff;
        if (push) begin
            nxt_mem[wp_ff] = in_if.data;
            nxt_wp         = ~wp_ff;
        end
        if (pop) begin
            nxt_rp = ~rp_ff;
        end
        nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
    end

    // registers only
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            wp_ff     <= 1'b0;
            rp_ff     <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            mem_ff    <= nxt_mem;
            wp_ff     <= nxt_wp;
            rp_ff     <= nxt_rp;
            cnt_ff    <= nxt_cnt;
        end
    end

    // full refuses the filler; data come straight from storage flops
    assign in_if.ready  = (cnt_ff != 2'h2);
    assign out_if.valid = (cnt_ff != 2'h0);
    assign out_if.data  = mem_ff[rp_ff];

    count_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cnt_ff != 2'h3) else $error("buffer count out of range");
endmodule : sepi_skid

/* src/sepi_front.sv */
// spi slave pin front end of a small byte-wide eeprom
// Contract
// - output bit changes only after clock falls
// - input bits sampled on clock rising edge
// - select high means deselected, output floats
// - standby when deselected and not writing
// - ignore instructions until first select fall
// - hold pauses transfer, floats output, ignores inputs
// - hold only begins while selected
// - write protect freezes block protect bits; the code freezes them only while the lock bit is set
// - opcode byte first; unknown opcode deselects
// - lock bit plus protect low blocks status writes
// - busy bit set during self-timed write
// - self-timed write ends within 5 ms
`timescale 1ns/1ps
`include "sepi_params.svh"
module sepi_front #(
    parameter int WRITE_CYC = `SEPI_WRITE_CYC  // self-timed write length in clocks
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // serial pins
    input  wire logic       sclk_i,
    input  wire logic       sel_n_i,
    input  wire logic       sdi_i,
    input  wire logic       hold_n_i,
    input  wire logic       wprot_n_i,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    // array-side byte stream (address and data after array opcodes)
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    output logic [7:0]      rx_data_o,
    output logic [7:0]      rx_opcode_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       array_write_go_i,
    // status view
    output logic [7:0]      status_o,
    output logic            standby_o,
    output logic            hardware_protected_mode_o,
    output logic            write_enable_latch_o
);
    // two-flop synchronisers for every pin
    logic [4:0] s1_ff, s2_ff, s3_ff;
    logic       clk_s, sel_s, sdi_s, hold_s, wp_s, clk_d, sel_d;
    logic       rise, fall, sel_fall, sel_rise, paused;

    // state registers with their next values
    sepi_pkg::sepi_phase_e phase_ff, nxt_phase;
    logic [7:0]  sh_ff, nxt_sh;             // receive shift register
    logic [2:0]  bit_ff, nxt_bit;           // bit count within byte
    logic [7:0]  tx_ff, nxt_tx;             // transmit shift register
    logic        sdo_ff, nxt_sdo;
    logic        armed_ff, nxt_armed;       // first select fall seen
    logic        wel_ff, nxt_wel;
    logic        bplo_ff, nxt_bplo, bphi_ff, nxt_bphi, lock_ff, nxt_lock;
    logic [7:0]  pend_ff, nxt_pend;         // status byte awaiting commit
    logic        pend_ok_ff, nxt_pend_ok;   // full byte seen, self-timed write starts on select rise
    logic        busy_ff, nxt_busy;
    logic        stwr_ff, nxt_stwr;         // running cycle is a status write
    logic [31:0] wcnt_ff, nxt_wcnt;
    logic [7:0]  op_ff, nxt_op;
    logic        hold_ff, nxt_hold;
    logic        hardware_protected_mode;

    // output buffer between byte capture and the user side
    sepi_buf_if #(.W(8)) fill_if ();
    sepi_buf_if #(.W(8)) drain_if ();

    // sorts an opcode into the recognised set
    function automatic logic op_known(input logic [7:0] op);
        return op == `SEPI_OP_OP_WRITE_ENABLE_CODE || op == `SEPI_OP_OP_WRITE_DISABLE_CODE ||
               op == `SEPI_OP_OP_STATUS_READ_CODE || op == `SEPI_OP_OP_STATUS_WRITE_CODE ||
               op == `SEPI_OP_READ_CODE || op == `SEPI_OP_WRITE_CODE;
    endfunction

    // first flop feeds only the second; third stage finds edges
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1_ff <= 5'h1e;
            s2_ff <= 5'h1e;
            s3_ff <= 5'h1e;
        end else begin
            s1_ff <= {wprot_n_i, hold_n_i, sdi_i, sel_n_i, sclk_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign clk_s  = s2_ff[0];
    assign sel_s  = s2_ff[1];
    assign sdi_s  = s2_ff[2];
    assign hold_s = s2_ff[3];
    assign wp_s   = s2_ff[4];
    assign clk_d  = s3_ff[0];
    assign sel_d  = s3_ff[1];
    assign rise     = clk_s & ~clk_d;
    assign fall     = ~clk_s & clk_d;
    assign sel_fall = ~sel_s & sel_d;
    assign sel_rise = sel_s & ~sel_d;
    assign hardware_protected_mode      = lock_ff & ~wp_s;
    assign paused   = hold_ff;

    // frame, shift and status control
    always_comb begin
        nxt_phase   = phase_ff;
        nxt_sh      = sh_ff;
        nxt_bit     = bit_ff;
        nxt_tx      = tx_ff;
        nxt_sdo     = sdo_ff;
        nxt_armed   = armed_ff;
        nxt_wel     = wel_ff;
        nxt_bplo    = bplo_ff;
        nxt_bphi    = bphi_ff;
        nxt_lock    = lock_ff;
        nxt_pend    = pend_ff;
        nxt_pend_ok = pend_ok_ff;
        nxt_busy    = busy_ff;
        nxt_stwr    = stwr_ff;
        nxt_wcnt    = wcnt_ff;
        nxt_op      = op_ff;
        nxt_hold    = hold_ff;
        fill_if.valid = 1'b0;
        fill_if.data  = sh_ff;
        // hold starts only while selected, and only with clock low
        if (sel_s)
            nxt_hold = 1'b0;
        else if (!hold_s && !clk_s)
            nxt_hold = 1'b1;
        else if (hold_s && !clk_s)
            nxt_hold = 1'b0;
        // self-timed write counts down, then clears busy and the latch
        if (busy_ff) begin
            if (wcnt_ff == 32'h1) begin
                nxt_busy = 1'b0;
                nxt_wel  = 1'b0;
                if (stwr_ff) begin
                    nxt_bplo = pend_ff[`SEPI_SR_BPLO_POS];
                    nxt_bphi = pend_ff[`SEPI_SR_BPHI_POS];
                    nxt_lock = pend_ff[`SEPI_SR_LOCK_POS];
                end
            end
            nxt_wcnt = wcnt_ff - 32'h1;
        end
        if (sel_fall) begin
            nxt_armed   = 1'b1;
            nxt_phase   = sepi_pkg::SEPI_OPCODE;
            nxt_bit     = 3'h0;
            nxt_pend_ok = 1'b0;
        end else if (sel_s) begin
            // deselected: frame closes, a full status byte starts its self-timed write now
            if (sel_rise && phase_ff == sepi_pkg::SEPI_WAIT && pend_ok_ff && !busy_ff) begin
                nxt_busy = 1'b1;
                nxt_stwr = 1'b1;
                nxt_wcnt = 32'(WRITE_CYC);
            end
            if (sel_rise && op_ff == `SEPI_OP_WRITE_CODE && array_write_go_i
                && wel_ff && !busy_ff) begin
                nxt_busy = 1'b1;
                nxt_stwr = 1'b0;
                nxt_wcnt = 32'(WRITE_CYC);
            end
            nxt_phase = sepi_pkg::SEPI_IDLE;
        end else if (!paused && armed_ff && phase_ff != sepi_pkg::SEPI_IDLE) begin
            if (rise) begin
                nxt_sh  = {sh_ff[6:0], sdi_s};
                nxt_bit = bit_ff + 3'h1;
                if (bit_ff == `SEPI_BIT_LAST) begin
                    unique case (phase_ff)
                        sepi_pkg::SEPI_OPCODE: begin
                            nxt_op = {sh_ff[6:0], sdi_s};
                            if (!op_known({sh_ff[6:0], sdi_s}))
                                nxt_phase = sepi_pkg::SEPI_IDLE;
                            else begin
                                unique case ({sh_ff[6:0], sdi_s})
                                    `SEPI_OP_OP_WRITE_ENABLE_CODE: begin
                                        nxt_wel   = ~busy_ff;
                                        nxt_phase = sepi_pkg::SEPI_WAIT;
                                    end
                                    `SEPI_OP_OP_WRITE_DISABLE_CODE: begin
                                        nxt_wel   = busy_ff & wel_ff;
                                        nxt_phase = sepi_pkg::SEPI_WAIT;
                                    end
                                    `SEPI_OP_OP_STATUS_READ_CODE:
                                        nxt_phase = sepi_pkg::SEPI_SRTX;
                                    `SEPI_OP_OP_STATUS_WRITE_CODE:
                                        nxt_phase = (wel_ff && !hardware_protected_mode && !busy_ff) ?
                                            sepi_pkg::SEPI_SRRX : sepi_pkg::SEPI_WAIT;
                                    default:
                                        nxt_phase = sepi_pkg::SEPI_PASS;
                                endcase
                            end
                        end
                        sepi_pkg::SEPI_SRRX: begin
                            nxt_pend    = {sh_ff[6:0], sdi_s};
                            nxt_pend_ok = 1'b1;
                            nxt_phase   = sepi_pkg::SEPI_WAIT;
                        end
                        sepi_pkg::SEPI_PASS: begin
                            fill_if.valid = 1'b1;
                            fill_if.data  = {sh_ff[6:0], sdi_s};
                        end
                        default: ;
                    endcase
                end else if (phase_ff == sepi_pkg::SEPI_WAIT) begin
                    nxt_pend_ok = 1'b0;  // extra clocks cancel a status write
                end
            end
            if (fall) begin
                // load a fresh byte at each byte boundary, then shift
                if (bit_ff == 3'h0)
                    nxt_tx = (phase_ff == sepi_pkg::SEPI_SRTX) ? status_o : tx_data_i;
                else
                    nxt_tx = {tx_ff[6:0], 1'b0};
                nxt_sdo = (bit_ff == 3'h0) ?
                    ((phase_ff == sepi_pkg::SEPI_SRTX) ? status_o[7] : tx_data_i[7])
                    : tx_ff[6];
            end
        end
    end

    // registers only
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            phase_ff   <= sepi_pkg::SEPI_IDLE;
            sh_ff      <= 8'h00;
            bit_ff     <= 3'h0;
            tx_ff      <= 8'h00;
            sdo_ff     <= 1'b0;
            armed_ff   <= 1'b0;
            wel_ff     <= 1'b0;
            bplo_ff    <= 1'b0;
            bphi_ff    <= 1'b0;
            lock_ff    <= 1'b0;
            pend_ff    <= `SEPI_SR_RESET;
            pend_ok_ff <= 1'b0;
            busy_ff    <= 1'b0;
            stwr_ff    <= 1'b0;
            wcnt_ff    <= 32'h0;
            op_ff      <= 8'h00;
            hold_ff    <= 1'b0;
        end else begin
            phase_ff   <= nxt_phase;
            sh_ff      <= nxt_sh;
            bit_ff     <= nxt_bit;
            tx_ff      <= nxt_tx;
            sdo_ff     <= nxt_sdo;
            armed_ff   <= nxt_armed;
            wel_ff     <= nxt_wel;
            bplo_ff    <= nxt_bplo;
            bphi_ff    <= nxt_bphi;
            lock_ff    <= nxt_lock;
            pend_ff    <= nxt_pend;
            pend_ok_ff <= nxt_pend_ok;
            busy_ff    <= nxt_busy;
            stwr_ff    <= nxt_stwr;
            wcnt_ff    <= nxt_wcnt;
            op_ff      <= nxt_op;
            hold_ff    <= nxt_hold;
        end
    end

    // a stall on the user side loses no byte while two fit
    sepi_skid #(.W(8)) u_skid (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .in_if     (fill_if.snk),
        .out_if    (drain_if.src)
    );
    assign drain_if.ready = rx_ready_i;
    assign rx_valid_o     = drain_if.valid;
    assign rx_data_o      = drain_if.data;
    assign rx_opcode_o    = op_ff;

    // status byte: bits 6..4 read zero; protect bits frozen by the pin via hpm
    assign status_o = {lock_ff, 3'h0, bphi_ff, bplo_ff, wel_ff, busy_ff};
    assign sdo_o                     = sdo_ff;
    assign sdo_oe_o  = !sel_s && !hold_ff && (phase_ff == sepi_pkg::SEPI_SRTX ||
                       phase_ff == sepi_pkg::SEPI_PASS);
    assign standby_o = sel_s && !busy_ff;
    assign hardware_protected_mode_o = hardware_protected_mode;
    assign write_enable_latch_o      = wel_ff;

    sequence busy_start_s;
        !busy_ff ##1 busy_ff;
    endsequence
    float_desel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sel_s |-> !sdo_oe_o) else $error("output driven while deselected");
    float_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hold_ff |-> !sdo_oe_o) else $error("output driven during hold");
    sdo_on_fall_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !fall |=> $stable(sdo_ff)) else $error("output moved without clock fall");
    standby_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        standby_o |=> phase_ff == sepi_pkg::SEPI_IDLE && !sdo_oe_o)
        else $error("frame still open in standby");
    armed_first_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !armed_ff |-> phase_ff == sepi_pkg::SEPI_IDLE) else $error("active before select fall");
    hold_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sel_s |=> !hold_ff) else $error("hold while deselected");
    busy_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        busy_start_s |-> busy_ff && wcnt_ff == 32'(WRITE_CYC)) else $error("write timer bad");
    hpm_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hardware_protected_mode && phase_ff == sepi_pkg::SEPI_OPCODE |=> phase_ff != sepi_pkg::SEPI_SRRX)
        else $error("status write taken in protected mode");
    unknown_op_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        phase_ff == sepi_pkg::SEPI_OPCODE && rise && !sel_s && !hold_ff && bit_ff == 3'h7
        && !op_known({sh_ff[6:0], sdi_s}) |=> phase_ff == sepi_pkg::SEPI_IDLE)
        else $error("unknown opcode not dropped");
    busy_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        busy_ff && wcnt_ff == 32'h1 |=> !busy_ff) else $error("busy not cleared");
endmodule : sepi_front

/* tb/sepi_host.sv */
// spi host model that drives the serial pins of the eeprom front end
`timescale 1ns/1ps
module sepi_host (
    // clock used only to pace the pins
    input  wire logic clk_sys_i,
    // pins toward the device
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      sdi_o,
    output logic      hold_n_o,
    output logic      wprot_n_o,
    // device output and its enable
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    logic sdi_bit = 1'b0;  // bit presented while selected
    logic junk_ff = 1'b0;  // data line keeps moving while deselected
    logic oe_gap  = 1'b0;  // some sample of the last byte saw a floating output

    initial begin
        sclk_o    = 1'b0;  // clock rests low outside frames
        sel_n_o   = 1'b1;
        hold_n_o  = 1'b1;
        wprot_n_o = 1'b1;
    end

    // a stale level must not pass for a driven one
    always @(posedge clk_sys_i) junk_ff <= ~junk_ff;
    assign sdi_o = sel_n_o ? junk_ff : sdi_bit;

    // wait n clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // select edge with a deselect gap on both sides, clock low throughout
    task automatic sel(input logic lvl);
        tick(8);
        sel_n_o = lvl;
        tick(8);
    endtask

    // hold changes only while the clock is low and the device is selected
    task automatic hold(input logic lvl);
        tick(4);
        hold_n_o = lvl;
        tick(8);
    endtask

    // write protect moves only between frames
    task automatic wprot(input logic lvl);
        tick(4);
        wprot_n_o = lvl;
        tick(4);
    endtask

    // one bit: present while low, sample the reply at the rising edge
    task automatic bitx(input logic b, output logic r);
        sdi_bit = b;
        tick(8);
        sclk_o = 1'b1;
        r = sdo_oe_i ? sdo_i : ~sdo_i;
        if (sdo_oe_i !== 1'b1) oe_gap = 1'b1;
        tick(8);
        sclk_o = 1'b0;
    endtask

    // one byte, msb first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        oe_gap = 1'b0;
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    endtask

    // whole frame: opcode, optionally one more byte, reply of the last byte
    task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input bit two,
                       output logic [7:0] rx);
        sel(1'b0);
        xfer(op, rx);
        if (two) xfer(arg, rx);
        sel(1'b1);
    endtask
endmodule // sepi_host

/* tb/spi_eeprom_pin_interface_tb_top.sv */
// self-checking bench for the serial eeprom pin front end
`timescale 1ns/1ps
`include "sepi_params.svh"
module spi_eeprom_pin_interface_tb_top;
    localparam int WC = 50;  // shortened self-timed write
    logic       clk_sys_i = 1'b0;
    logic       rst_n_i;
    logic       sclk, sel_n, sdi, hold_n, wprot_n, sdo, sdo_oe;
    logic       rx_valid, standby, hardware_protected_mode, wel;
    logic       rx_ready;          // drained unless a stall is wanted
    logic       awgo;              // array write frame complete
    logic [7:0] tx_data;           // byte shifted out during array reads
    logic [7:0] rx_data, rx_opcode, status, r;
    int         err_total = 0;
    int         n_checks  = 0;
    int         cyc       = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    sepi_host host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi),
        .hold_n_o(hold_n), .wprot_n_o(wprot_n), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

    sepi_front #(.WRITE_CYC(WC)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk), .sel_n_i(sel_n), .sdi_i(sdi), .hold_n_i(hold_n),
        .wprot_n_i(wprot_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .rx_data_o(rx_data), .rx_opcode_o(rx_opcode),
        .tx_data_i(tx_data), .array_write_go_i(awgo), .status_o(status),
        .standby_o(standby), .hardware_protected_mode_o(hardware_protected_mode),
        .write_enable_latch_o(wel));

    // verdict and end of run
    task automatic summarize();
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    // bounded wait for the self-timed write to finish
    task automatic wait_idle();
        for (int n = 0; n < 4 * WC && status[0] !== 1'b0; n++) host.tick(1);
    endtask

    // cut a hang short; a full run takes well under 15000 cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        rst_n_i  = 1'b0;
        rx_ready = 1'b1;
        awgo     = 1'b0;
        tx_data  = 8'h00;
        repeat (16) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        host.tick(4);
        chk1(sdo_oe, 1'b0);
        chk8(status, `SEPI_SR_RESET);
        chk1(standby, 1'b1);
        // first frame after reset opens with a select fall
        host.sel(1'b0);
        chk1(standby, 1'b0);
        host.xfer(`SEPI_OP_OP_WRITE_ENABLE_CODE, r);
        host.sel(1'b1);
        chk1(wel, 1'b1);
        chk1(sdo_oe, 1'b0);
        host.cmd(`SEPI_OP_OP_STATUS_READ_CODE, 8'h00, 1, r);
        chk8(r, 8'h02);
        chk1(host.oe_gap, 1'b0);
        // status write: old protect bits hold until the cycle ends
        host.cmd(`SEPI_OP_OP_STATUS_WRITE_CODE, 8'h8c, 1, r);
        chk1(status[0], 1'b1);
        chk8(status & 8'h8c, 8'h00);
        chk1(standby, 1'b0);
        wait_idle();
        chk8(status, 8'h8c);
        // hold in the middle of a status read: extra clocks must not shift
        host.sel(1'b0);
        host.xfer(`SEPI_OP_OP_STATUS_READ_CODE, r);
        for (int i = 7; i >= 4; i--) host.bitx(1'b0, r[i]);
        host.hold(1'b0);
        chk1(sdo_oe, 1'b0);
        for (int i = 0; i < 3; i++) host.bitx(1'b1, r[0]);
        host.hold(1'b1);
        for (int i = 3; i >= 0; i--) host.bitx(1'b0, r[i]);
        host.sel(1'b1);
        chk8(r, 8'h8c);
        // lock bit with protect low refuses status writes
        host.wprot(1'b0);
        chk1(hardware_protected_mode, 1'b1);
        host.cmd(`SEPI_OP_OP_WRITE_ENABLE_CODE, 8'h00, 0, r);
        host.cmd(`SEPI_OP_OP_STATUS_WRITE_CODE, 8'h00, 1, r);
        chk8(status & 8'h8d, 8'h8c);
        host.wprot(1'b1);
        chk1(hardware_protected_mode, 1'b0);
        host.cmd(`SEPI_OP_OP_WRITE_ENABLE_CODE, 8'h00, 0, r);
        host.cmd(`SEPI_OP_OP_STATUS_WRITE_CODE, 8'h00, 1, r);
        wait_idle();
        chk8(status, 8'h00);
        // extra clocks after the status byte cancel the write
        host.cmd(`SEPI_OP_OP_WRITE_ENABLE_CODE, 8'h00, 0, r);
        host.sel(1'b0);
        host.xfer(`SEPI_OP_OP_STATUS_WRITE_CODE, r);
        host.xfer(8'h8c, r);
        host.xfer(8'h00, r);
        host.sel(1'b1);
        chk8(status, 8'h02);
        // latch set then cleared
        host.cmd(`SEPI_OP_OP_WRITE_ENABLE_CODE, 8'h00, 0, r);
        host.cmd(`SEPI_OP_OP_WRITE_DISABLE_CODE, 8'h00, 0, r);
        chk1(wel, 1'b0);
        // status write without the latch is ignored
        host.cmd(`SEPI_OP_OP_STATUS_WRITE_CODE, 8'h8c, 1, r);
        chk8(status, 8'h00);
        // unknown opcode drops the rest of the frame
        host.cmd(8'hff, `SEPI_OP_OP_WRITE_ENABLE_CODE, 1, r);
        chk1(wel, 1'b0);
        // array write runs a self-timed cycle and clears the latch
        host.cmd(`SEPI_OP_OP_WRITE_ENABLE_CODE, 8'h00, 0, r);
        awgo = 1'b1;
        host.cmd(`SEPI_OP_WRITE_CODE, 8'h11, 1, r);
        chk8(rx_opcode, `SEPI_OP_WRITE_CODE);
        chk1(status[0], 1'b1);
        awgo = 1'b0;
        wait_idle();
        chk1(wel, 1'b0);
        // two bytes wait in the buffer while the user side stalls
        rx_ready = 1'b0;
        tx_data = 8'h3c;
        host.sel(1'b0);
        host.xfer(`SEPI_OP_READ_CODE, r);
        host.xfer(8'h5a, r);
        chk8(r, 8'h3c);
        tx_data = 8'hc3;
        host.xfer(8'ha5, r);
        chk8(r, 8'hc3);
        chk1(host.oe_gap, 1'b0);
        host.sel(1'b1);
        chk8(rx_opcode, `SEPI_OP_READ_CODE);
        chk1(rx_valid, 1'b1);
        chk8(rx_data, 8'h5a);
        rx_ready = 1'b1;
        host.tick(1);
        rx_ready = 1'b0;
        chk1(rx_valid, 1'b1);
        chk8(rx_data, 8'ha5);
        rx_ready = 1'b1;
        host.tick(2);
        chk1(rx_valid, 1'b0);
        summarize();
    end
endmodule // spi_eeprom_pin_interface_tb_top
